/* core/pbdc_top.sv */
// Purpose: Digital control of a loop clock generator: bandwidth, dividers, lock flag
// Assumes: Analog loop outside; lock and track inputs come from the detector
// Notes: Avalon-MM slave, one wait state on every access
// Function
// - Automatic bit selects auto or manual bandwidth
// - Settled bit reads lock only in auto
// - Track bit: status in auto, control manual
// - Manual track value kept through auto mode
// - Reset clears track bit to acquisition
// - Feedback divider split high nibble, resets 64
// - Feedback divider zero acts as one
// - Divider and range writes ignored while powered
// - Range register holds multiplier, resets 64
// - Range zero disables loop, clears base select
// - Range zero refuses setting base select
// - Reference divider four bits, zero acts one
// - Lock change sets flag; enable gates request
// - Manual mode: no request, flag reads zero
// - Base select allowed while unlocked
// - Wait mode leaves generator state unchanged
// - Stop mode shuts loop analog down
// - Break protects flag unless clear allowed
// - Control register read clears lock flag
// - Power off refused while selected, and reverse
// - Irq enable ignores writes, reads zero manual
module pbdc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [pbdc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic freq_settled_async,
  input wire logic loop_tracking,
  output logic lock_irq,
  output logic loop_enable,
  output logic loop_analog_on,
  output logic base_clk_select,
  output logic fast_track_sel,
  output logic [11:0] feedback_div_n,
  output logic [7:0] vco_range_l,
  output logic [3:0] ref_div_r
);
  // ==========================================================================
  // Bus handshake: one wait state, accept on second cycle
  // ==========================================================================
  typedef enum logic [0:0] {
    PBDC_BUS_IDLE = 1'b0,
    PBDC_BUS_ACK = 1'b1
  } pbdc_bus_state_t;
  pbdc_bus_state_t bus_state_r;
  logic bus_ack;
  logic [7:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic wr_lane0;
  assign idx = avs_address[9:2];
  assign bus_ack = (bus_state_r == PBDC_BUS_ACK);
  assign wr_acc = avs_write && bus_ack;
  assign rd_acc = avs_read && bus_ack;
  assign wr_lane0 = wr_acc && avs_byteenable[0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_state_r <= PBDC_BUS_IDLE;
    end else begin
      case (bus_state_r)
        PBDC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_r <= PBDC_BUS_ACK;
          end
        end
        // Always back to idle: a held request costs one idle cycle per access
        PBDC_BUS_ACK: begin
          bus_state_r <= PBDC_BUS_IDLE;
        end
        default: begin
          bus_state_r <= PBDC_BUS_IDLE;
        end
      endcase
    end
  end

  // Registered so the answer never hangs on a combinational path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !bus_ack);
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  logic auto_r;
  logic track_shadow_r;
  logic irq_en_r;
  logic power_on_r;
  logic base_sel_r;
  logic break_r;
  logic break_clr_r;
  logic stop_r;
  logic wait_r;
  logic [11:0] fb_div_r;
  logic [7:0] range_r;
  logic [3:0] rdiv_r;
  logic [7:0] wd;
  logic range_zero;
  logic lock_s;
  assign wd = avs_writedata[7:0];
  assign range_zero = (range_r == 8'h00);

  // ==========================================================================
  // Write strobes
  // ==========================================================================
  logic wr_bw;
  logic wr_ctrl;
  logic wr_sys;
  logic wr_div;
  assign wr_bw = wr_lane0 && (idx == pbdc_pkg::IDX_LOOP_BW);
  assign wr_ctrl = wr_lane0 && (idx == pbdc_pkg::IDX_LOOP_CTRL);
  assign wr_sys = wr_lane0 && (idx == pbdc_pkg::IDX_SYS_CTRL);
  // Divider side is frozen while the loop runs
  assign wr_div = wr_lane0 && !power_on_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      auto_r <= 1'b0;
      track_shadow_r <= 1'b0;
    end else if (wr_bw) begin
      auto_r <= wd[pbdc_pkg::BW_AUTO];
      // Write to settled bit is test-only; ignored here
      if (!auto_r) begin
        track_shadow_r <= wd[pbdc_pkg::BW_TRACK];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
    end else if (!auto_r) begin
      irq_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_r <= wd[pbdc_pkg::LC_IRQ_EN];
    end
  end

  // Power on resets set so the loop settles during power-up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      power_on_r <= 1'b1;
    end else if (wr_ctrl) begin
      // Clear also refused when this same write selects the loop clock
      if (wd[pbdc_pkg::LC_POWER_ON] || (!base_sel_r && !wd[pbdc_pkg::LC_BASE_SEL])) begin
        power_on_r <= wd[pbdc_pkg::LC_POWER_ON];
      end
    end
  end

  // Lock state not checked: software must verify lock first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      base_sel_r <= 1'b0;
    end else if (range_zero) begin
      base_sel_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (!wd[pbdc_pkg::LC_BASE_SEL] || power_on_r) begin
        base_sel_r <= wd[pbdc_pkg::LC_BASE_SEL];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fb_div_r <= pbdc_pkg::RST_FB_DIV_N;
      range_r <= pbdc_pkg::RST_VCO_RANGE_L;
      rdiv_r <= pbdc_pkg::RST_REF_DIV_R;
    end else if (wr_div) begin
      case (idx)
        pbdc_pkg::IDX_FB_DIV_HIGH: fb_div_r[11:8] <= wd[3:0];
        pbdc_pkg::IDX_FB_DIV_LOW: fb_div_r[7:0] <= wd;
        pbdc_pkg::IDX_VCO_RANGE: range_r <= wd;
        pbdc_pkg::IDX_REF_DIV: rdiv_r <= wd[3:0];
        default: ;
      endcase
    end
  end

  // Wait state is recorded only; it never touches generator state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      break_r <= 1'b0;
      break_clr_r <= 1'b0;
      stop_r <= 1'b0;
      wait_r <= 1'b0;
    end else if (wr_sys) begin
      break_r <= wd[pbdc_pkg::SC_BREAK];
      break_clr_r <= wd[pbdc_pkg::SC_BREAK_CLR];
      stop_r <= wd[pbdc_pkg::SC_STOP];
      wait_r <= wd[pbdc_pkg::SC_WAIT];
    end
  end

  // ==========================================================================
  // Lock detection and change flag
  // ==========================================================================
  logic sync1_r;
  logic sync2_r;
  logic lock_prev_r;
  logic flag_r;
  logic flag_clr;
  logic flag_seen_r;
  assign lock_s = sync2_r;

  // Only the second stage feeds the edge compare, never the first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      lock_prev_r <= 1'b0;
    end else begin
      sync1_r <= freq_settled_async;
      sync2_r <= sync1_r;
      lock_prev_r <= sync2_r;
    end
  end

  // Flag value carried by the answer, captured with the read data.
  // Only a flag that software has seen is cleared, so a lock change
  // landing between capture and accept is not lost.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_seen_r <= 1'b0;
    end else if (avs_read && !bus_ack) begin
      flag_seen_r <= flag_r;
    end
  end

  // Read clear blocked in break unless clearing is allowed
  assign flag_clr = rd_acc && idx == pbdc_pkg::IDX_LOOP_CTRL && flag_seen_r
    && (!break_r || break_clr_r);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (!auto_r) begin
      flag_r <= 1'b0;
    end else if (lock_s != lock_prev_r) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux
  // ==========================================================================
  logic [7:0] rd_byte;
  logic settled_rd;
  logic track_rd;
  assign settled_rd = auto_r && lock_s;
  assign track_rd = auto_r ? loop_tracking : track_shadow_r;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      pbdc_pkg::IDX_FB_DIV_HIGH: rd_byte = {4'h0, fb_div_r[11:8]};
      pbdc_pkg::IDX_FB_DIV_LOW: rd_byte = fb_div_r[7:0];
      pbdc_pkg::IDX_VCO_RANGE: rd_byte = range_r;
      pbdc_pkg::IDX_REF_DIV: rd_byte = {4'h0, rdiv_r};
      pbdc_pkg::IDX_LOOP_CTRL: begin
        rd_byte = {irq_en_r, flag_r, power_on_r, base_sel_r, 4'h0};
      end
      pbdc_pkg::IDX_LOOP_BW: begin
        rd_byte = {auto_r, settled_rd, track_rd, 5'h00};
      end
      pbdc_pkg::IDX_SYS_CTRL: begin
        rd_byte = {4'h0, wait_r, stop_r, break_clr_r, break_r};
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Loaded on the request edge so data stand when waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================================
  // Outputs to the analog loop, all registered
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_irq <= 1'b0;
    end else begin
      lock_irq <= auto_r && irq_en_r && flag_r;
    end
  end

  // Range zero and stop both take the analog side down
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      loop_enable <= 1'b0;
      loop_analog_on <= 1'b0;
    end else begin
      loop_enable <= power_on_r && !range_zero;
      loop_analog_on <= power_on_r && !range_zero && !stop_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      base_clk_select <= 1'b0;
      fast_track_sel <= 1'b0;
    end else begin
      base_clk_select <= base_sel_r && !range_zero;
      fast_track_sel <= track_rd;
    end
  end

  // Zero divider codes leave as one so the analog divider never sees zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      feedback_div_n <= pbdc_pkg::RST_FB_DIV_N;
      vco_range_l <= pbdc_pkg::RST_VCO_RANGE_L;
      ref_div_r <= pbdc_pkg::RST_REF_DIV_R;
    end else begin
      feedback_div_n <= (fb_div_r == 12'h000) ? 12'h001 : fb_div_r;
      vco_range_l <= range_r;
      ref_div_r <= (rdiv_r == 4'h0) ? 4'h1 : rdiv_r;
    end
  end
endmodule

/* core/pbdc_pkg.sv */
// Purpose: Shared constants for the loop bandwidth and divider control block
// Assumes: Avalon-MM byte addressing, one 8-bit register per 32-bit word
// Notes: Byte addresses are four times the register index
package pbdc_pkg;
  // ==========================================================================
  // Register indices and address width
  // ==========================================================================
  localparam logic [7:0] IDX_FB_DIV_HIGH = 8'h38;
  localparam logic [7:0] IDX_FB_DIV_LOW = 8'h39;
  localparam logic [7:0] IDX_VCO_RANGE = 8'h3A;
  localparam logic [7:0] IDX_REF_DIV = 8'h3B;
  localparam logic [7:0] IDX_LOOP_CTRL = 8'h3C;
  localparam logic [7:0] IDX_LOOP_BW = 8'h3D;
  localparam logic [7:0] IDX_SYS_CTRL = 8'h3E;
  localparam int ADDR_W = 10;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [11:0] RST_FB_DIV_N = 12'h040;
  localparam logic [7:0] RST_VCO_RANGE_L = 8'h40;
  localparam logic [3:0] RST_REF_DIV_R = 4'h1;
  // ==========================================================================
  // Loop control register fields
  // ==========================================================================
  localparam int LC_IRQ_EN = 7;
  localparam int LC_FLAG = 6;
  localparam int LC_POWER_ON = 5;
  localparam int LC_BASE_SEL = 4;
  // ==========================================================================
  // Loop bandwidth register fields
  // ==========================================================================
  localparam int BW_AUTO = 7;
  localparam int BW_SETTLED = 6;
  localparam int BW_TRACK = 5;
  // ==========================================================================
  // System control register fields
  // ==========================================================================
  localparam int SC_BREAK = 0;
  localparam int SC_BREAK_CLR = 1;
  localparam int SC_STOP = 2;
  localparam int SC_WAIT = 3;
endpackage

/* tb/pbdc_properties.sv */
// Purpose: Port timing checks for the loop control block
// Assumes: One clock domain, top ports only
// Notes: Bound to every top instance
module pbdc_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic lock_irq,
  input wire logic loop_enable,
  input wire logic loop_analog_on,
  input wire logic base_clk_select,
  input wire logic [11:0] feedback_div_n,
  input wire logic [7:0] vco_range_l,
  input wire logic [3:0] ref_div_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Properties
  property p_sel_range; base_clk_select |-> vco_range_l != 8'h00; endproperty
  property p_sel_power; base_clk_select |-> loop_enable; endproperty
  property p_n_one; feedback_div_n != 12'h000; endproperty
  property p_r_one; ref_div_r != 4'h0; endproperty
  property p_range_off; vco_range_l == 8'h00 |-> ##[0:1] !loop_enable; endproperty
  property p_stop_off; loop_analog_on |-> loop_enable; endproperty
  // Output may trail the register by one stage
  property p_n_hold;
    $changed(feedback_div_n) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  property p_l_hold;
    $changed(vco_range_l) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  property p_ack; $rose(avs_read) |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_sel_range: assert property (p_sel_range)
    else $error("base select on zero range");
  a_sel_power: assert property (p_sel_power)
    else $error("base select while loop off");
  a_n_one: assert property (p_n_one)
    else $error("feedback divider zero");
  a_r_one: assert property (p_r_one)
    else $error("reference divider zero");
  a_range_off: assert property (p_range_off)
    else $error("loop on with zero range");
  a_stop_off: assert property (p_stop_off)
    else $error("analog on while loop off");
  a_n_hold: assert property (p_n_hold)
    else $error("divider changed without write");
  a_l_hold: assert property (p_l_hold)
    else $error("range changed without write");
  a_ack: assert property (p_ack)
    else $error("read not answered in one wait");
  c_irq: cover property ($rose(lock_irq));
  c_sel: cover property ($rose(base_clk_select));
  c_stop: cover property ($fell(loop_analog_on));
endmodule
bind pbdc_top pbdc_properties u_props (.*);

/* tb/pbdc_analog_model.sv */
// Purpose: Behavioural lock detector facing the block
// Assumes: Lock wanted only when the bench asks
// Notes: Tracking follows lock
module pbdc_analog_model (
  input wire logic sys_clk,
  input wire logic analog_on,
  input wire logic lock_req,
  output logic settled,
  output logic tracking
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // No lock while analog is down
  always_ff @(posedge sys_clk) begin
    if (!analog_on || !lock_req) cnt_r <= 4'h0;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
  end
  assign settled = cnt_r > 4'h8;
  assign tracking = settled;
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the loop control block
// Assumes: One wait state bus, analog model on far side
// Notes: Reads queue their expectation, a monitor compares
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] NH = pbdc_pkg::IDX_FB_DIV_HIGH;
  localparam logic [7:0] NL = pbdc_pkg::IDX_FB_DIV_LOW;
  localparam logic [7:0] LR = pbdc_pkg::IDX_VCO_RANGE;
  localparam logic [7:0] RD = pbdc_pkg::IDX_REF_DIV;
  localparam logic [7:0] LC = pbdc_pkg::IDX_LOOP_CTRL;
  localparam logic [7:0] BW = pbdc_pkg::IDX_LOOP_BW;
  localparam logic [7:0] SC = pbdc_pkg::IDX_SYS_CTRL;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [pbdc_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, e_r;
  logic avs_waitrequest, freq_settled_async, loop_tracking, lock_irq;
  logic loop_enable, loop_analog_on, base_clk_select, fast_track_sel;
  logic [11:0] feedback_div_n;
  logic [7:0] vco_range_l, rnd;
  logic [3:0] ref_div_r;
  logic lock_req = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hbeec;
  logic [31:0] exp_q[$];
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
  always #20 sys_clk = ~sys_clk;
  pbdc_top DUT (.*);
  pbdc_analog_model u_model (.sys_clk(sys_clk), .analog_on(loop_analog_on),
    .lock_req(lock_req), .settled(freq_settled_async), .tracking(loop_tracking));
  // ==========
  // Bus tasks
  task automatic acc(input logic [7:0] idx, input logic w, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    acc(idx, 1'b0, 8'h00);
  endtask
  task automatic settle(input logic lk);
    lock_req <= lk;
    repeat (24) @(posedge sys_clk);
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e_r = exp_q.pop_front();
      `CHK(avs_readdata, e_r)
    end
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
  // ==========
  // Scenarios
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(NH, 8'h00);
    rd(BW, 8'h00);
    rd(LC, 8'h20);
    `CHK(fast_track_sel, 1'b0)
    `CHK(feedback_div_n, 12'h040)
    for (int i = 0; i < 3; i++) begin
      wr(NL + 8'(i), 8'h00);
      rd(NL + 8'(i), i == 2 ? 8'h01 : 8'h40);
    end
    wr(LC, 8'h00);
    wr(NH, 8'hFF);
    rd(NH, 8'h0F);
    rnd = 8'($random(seed));
    wr(NL, rnd);
    rd(NL, rnd);
    wr(NH, 8'h00);
    wr(RD, 8'h00);
    wr(NL, 8'h00);
    rd(NL, 8'h00);
    `CHK(feedback_div_n, 12'h001)
    `CHK(ref_div_r, 4'h1)
    wr(RD, 8'h01);
    wr(LC, 8'h10);
    rd(LC, 8'h00);
    wr(LC, 8'h20);
    wr(LC, 8'h30);
    wr(LC, 8'h10);
    rd(LC, 8'h30);
    `CHK(base_clk_select, 1'b1)
    wr(LC, 8'h20);
    wr(LC, 8'h00);
    wr(LR, 8'h00);
    wr(LC, 8'h20);
    wr(LC, 8'h30);
    rd(LC, 8'h20);
    `CHK(loop_enable, 1'b0)
    `CHK(vco_range_l, 8'h00)
    `CHK(base_clk_select, 1'b0)
    wr(LC, 8'h00);
    wr(LR, 8'h40);
    wr(LC, 8'h20);
    wr(BW, 8'h20);
    rd(BW, 8'h20);
    `CHK(fast_track_sel, 1'b1)
    wr(BW, 8'hA0);
    settle(1'b1);
    rd(BW, 8'hE0);
    `CHK(fast_track_sel, 1'b1)
    wr(LC, 8'hA0);
    rd(LR, 8'h40);
    `CHK(vco_range_l, 8'h40)
    `CHK(lock_irq, 1'b1)
    rd(LC, 8'hE0);
    rd(LC, 8'hA0);
    `CHK(lock_irq, 1'b0)
    wr(LC, 8'h20);
    settle(1'b0);
    rd(LC, 8'h60);
    `CHK(lock_irq, 1'b0)
    wr(SC, 8'h01);
    settle(1'b1);
    rd(LC, 8'h60);
    rd(LC, 8'h60);
    wr(SC, 8'h03);
    rd(LC, 8'h60);
    wr(SC, 8'h00);
    rd(LC, 8'h20);
    wr(BW, 8'h00);
    rd(BW, 8'h20);
    wr(LC, 8'hA0);
    rd(LC, 8'h20);
    `CHK(lock_irq, 1'b0)
    wr(SC, 8'h08);
    rd(8'h10, 8'h00);
    `CHK(loop_analog_on, 1'b1)
    wr(SC, 8'h04);
    rd(8'h10, 8'h00);
    `CHK(loop_analog_on, 1'b0)
    conclude();
  end
endmodule
